// ==== verilog/pse_channel_mode_status_regs.sv ====
// mode and status register bank of a four-channel group, reached over i2c
`timescale 1ns/1ps
`default_nettype none
`include "pse_regs_cfg.svh"
module pse_channel_mode_status_regs import pse_regs_pkg::*; #(
  parameter int NCH = `NUM_CHAN
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // i2c pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address straps
  input wire logic [3:0] address_strap_pins,
  input wire logic group_select_bit,
  input wire logic config_b,
  // from the power engine
  input wire logic [NCH-1:0] chan_on,
  input wire logic [NCH-1:0] drain_low,
  input wire disc_in_t [NCH-1:0] disc_in,
  input wire logic alloc_15w5,
  // to the channel engines
  output logic [2*NCH-1:0] channel_mode_field,
  output logic [NCH-1:0] power_allow,
  output logic [NCH-1:0] probe_allow,
  output logic [NCH-1:0] off_clear,
  output logic [NCH-1:0] supply_good_change_flag,
  output logic [NCH-1:0] channel_on_change_flag
);
  reg_req_t req;
  logic [7:0] rdata;
  logic [6:0] own_addr;
  logic [7:0] mode_q, mode_d;
  logic [3:0] strap_q, strap_d;
  logic group_q, group_d, caught_q, caught_d;
  logic [NCH-1:0] supply_good_flags, channel_on_flags, off_entry;
  logic [NCH-1:0] allow_d, probe_d;
  logic [7:0] disc_q [NCH];
  logic [7:0] asgn_q [NCH];

  // the pin is only ever pulled low
  assign sda_out = 1'b0;

  // device address from captured straps
  assign own_addr = {`ADDR_PREFIX, strap_q, group_q};

  i2c_reg_slave u_i2c (
    .clk(clk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .own_addr(own_addr),
    .req(req),
    .rdata(rdata)
  );

  // mode write and strap capture one cycle after reset release
  always_comb begin
    mode_d = mode_q;
    if (req.wr && req.addr == `REG_MODE) begin
      mode_d = req.wdata;
    end
    caught_d = 1'b1;
    strap_d = caught_q ? strap_q : address_strap_pins;
    group_d = caught_q ? group_q : (group_select_bit & ~config_b);
  end

  // mode and strap registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= `MODE_RESET;
      strap_q <= 4'h0;
      group_q <= 1'b0;
      caught_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      strap_q <= strap_d;
      group_q <= group_d;
      caught_q <= caught_d;
    end
  end

  // per-channel flags and class records
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    mode_t ch_mode;
    logic [7:0] disc_d, asgn_d;
    logic up4;
    assign ch_mode = mode_t'(mode_q[2*i +: 2]);

    chan_power_flags u_flags (
      .clk(clk),
      .rst_b(rst_b),
      .mode(ch_mode),
      .chan_on(chan_on[i]),
      .drain_low(drain_low[i]),
      .supply_good_q(supply_good_flags[i]),
      .chan_on_q(channel_on_flags[i]),
      .off_entry_q(off_entry[i]),
      .sg_change_q(supply_good_change_flag[i]),
      .on_change_q(channel_on_change_flag[i])
    );

    // class 4 and up covers single and dual signature codes
    assign up4 = (disc_q[i][7:4] == `CLASS_4) || (disc_q[i][7:4] == `CLASS_5_DS) ||
      (disc_q[i][7:4] >= `CLASS_5_SS && disc_q[i][7:4] <= `CLASS_8_SS);

    // requested and assigned class bookkeeping
    always_comb begin
      disc_d = disc_q[i];
      asgn_d = asgn_q[i];
      if (ch_mode == MODE_OFF || off_entry[i]) begin
        disc_d = 8'h00;
        asgn_d = 8'h00;
      end else if (chan_on[i] && !channel_on_flags[i]) begin
        if (alloc_15w5 && up4) begin
          disc_d[7:4] = `CLASS_4P_LIM;
        end
        if (ch_mode != MODE_MANUAL) begin
          asgn_d[3:0] = asgn_q[i][7:4]; // previous class
          if (disc_q[i][7:4] == `CLASS_0) begin
            asgn_d[7:4] = `CLASS_3;
          end else if (alloc_15w5 && up4) begin
            asgn_d[7:4] = `CLASS_4;
          end else begin
            asgn_d[7:4] = disc_q[i][7:4];
          end
        end
      end else if (disc_in[i].valid && !channel_on_flags[i]) begin
        disc_d = {disc_in[i].rclass, disc_in[i].detect};
      end
    end

    // class registers
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        disc_q[i] <= 8'h00;
        asgn_q[i] <= 8'h00;
      end else begin
        disc_q[i] <= disc_d;
        asgn_q[i] <= asgn_d;
      end
    end

    // power and probing are withheld in off mode
    assign allow_d[i] = ch_mode != MODE_OFF;
    assign probe_d[i] = ch_mode != MODE_OFF;
  end

  // read data for the slave
  always_comb begin
    rdata = `UNMAPPED_DATA;
    if (req.addr >= `REG_DISC_BASE && req.addr <= `REG_DISC_LAST) begin
      rdata = disc_q[req.addr[1:0]];
    end else if (req.addr >= `REG_ASGN_BASE && req.addr <= `REG_ASGN_LAST) begin
      rdata = asgn_q[req.addr[1:0]];
    end else if (req.addr == `REG_POWER) begin
      rdata = {supply_good_flags, channel_on_flags};
    end else if (req.addr == `REG_STRAP) begin
      rdata = {1'b0, strap_q, group_q, 2'h0};
    end else if (req.addr == `REG_MODE) begin
      rdata = mode_q;
    end
  end

  // registered outputs to the channel engines
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel_mode_field <= `MODE_RESET;
      power_allow <= '0;
      probe_allow <= '0;
      off_clear <= '0;
    end else begin
      channel_mode_field <= mode_q;
      power_allow <= allow_d;
      probe_allow <= probe_d;
      off_clear <= off_entry;
    end
  end
endmodule // pse_channel_mode_status_regs
`default_nettype wire

// ==== verilog/pse_regs_cfg.svh ====
// register offsets, field positions, codes and reset values of the mode/status bank
`ifndef PSE_REGS_CFG_SVH
`define PSE_REGS_CFG_SVH
`define NUM_CHAN 4
`define REG_DISC_BASE 8'h0c
`define REG_DISC_LAST 8'h0f
`define REG_POWER 8'h10
`define REG_STRAP 8'h11
`define REG_MODE 8'h12
`define REG_ASGN_BASE 8'h4c
`define REG_ASGN_LAST 8'h4f
`define MODE_RESET 8'h00
`define UNMAPPED_DATA 8'h00
`define ADDR_PREFIX 2'h1
`define ADDR_BCAST 7'h7f
`define CLASS_NONE 4'h0
`define CLASS_3 4'h3
`define CLASS_4 4'h4
`define CLASS_0 4'h6
`define CLASS_5_SS 4'h8
`define CLASS_8_SS 4'hb
`define CLASS_4P_LIM 4'hc
`define CLASS_5_DS 4'hd
`define STRAP_LSB 3
`define GROUP_BIT 2
`define PG_LSB 4
`define OFF_SETTLE_MS 5
`endif

// ==== verilog/pse_regs_pkg.sv ====
// types shared by the mode/status bank
package pse_regs_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMI = 2'h2,
    MODE_AUTO = 2'h3
  } mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WDATA = 3'h2,
    ST_WACK = 3'h6,
    ST_RDATA = 3'h7,
    ST_RACK = 3'h5
  } i2c_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic [3:0] rclass;
    logic [3:0] detect;
  } disc_in_t;
endpackage

// ==== verilog/i2c_reg_slave.sv ====
// i2c slave: pointer byte then data bytes, auto-increment
`timescale 1ns/1ps
`default_nettype none
`include "pse_regs_cfg.svh"
module i2c_reg_slave import pse_regs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // address to answer
  input wire logic [6:0] own_addr,
  // register side
  output reg_req_t req,
  input wire logic [7:0] rdata
);
  i2c_state_t st_q, st_d;
  logic scl_q, sda_q, scl_d, sda_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d, first_q, first_d, oe_d;
  reg_req_t req_d;
  logic rise, fall, start, stop;

  // bus condition detection on sampled pins
  assign rise = scl_in & ~scl_q;
  assign fall = ~scl_in & scl_q;
  assign start = scl_in & scl_q & sda_q & ~sda_in;
  assign stop = scl_in & scl_q & ~sda_q & sda_in;

  // next state of the byte engine
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    first_d = first_q;
    ptr_d = ptr_q;
    oe_d = sda_oe;
    scl_d = scl_in;
    sda_d = sda_in;
    req_d = '0;
    req_d.addr = ptr_q;
    if (start) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (rise && (st_q == ST_ADDR || st_q == ST_WDATA)) begin
      sh_d = {sh_q[6:0], sda_in};
      cnt_d = cnt_q + 4'h1;
    end else if (rise && st_q == ST_RACK && sda_in) begin
      st_d = ST_IDLE; // master nack ends the read
    end else if (fall) begin
      unique case (st_q)
        ST_IDLE: st_d = ST_IDLE;
        ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (sh_q[7:1] == own_addr || sh_q[7:1] == `ADDR_BCAST) begin
              st_d = ST_AACK;
              rw_d = sh_q[0];
              first_d = 1'b1;
              oe_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_AACK, ST_RACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            st_d = ST_RDATA;
            sh_d = rdata;
            req_d.rd = 1'b1;
            ptr_d = ptr_q + 8'h01;
            oe_d = ~rdata[7];
          end else begin
            st_d = ST_WDATA;
            oe_d = 1'b0;
          end
        end
        ST_WDATA: begin
          if (cnt_q == 4'h8) begin
            st_d = ST_WACK;
            oe_d = 1'b1;
            first_d = 1'b0;
            if (first_q) begin
              ptr_d = sh_q;
            end else begin
              req_d.wr = 1'b1;
              req_d.wdata = sh_q;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_WACK: begin
          st_d = ST_WDATA;
          cnt_d = 4'h0;
          oe_d = 1'b0;
        end
        ST_RDATA: begin
          cnt_d = cnt_q + 4'h1;
          sh_d = {sh_q[6:0], 1'b0};
          if (cnt_q == 4'h7) begin
            st_d = ST_RACK;
            oe_d = 1'b0;
          end else begin
            oe_d = ~sh_q[6];
          end
        end
      endcase
    end
  end

  // registers of the byte engine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ptr_q <= 8'h00;
      sda_oe <= 1'b0;
      req <= '0;
    end else begin
      st_q <= st_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      first_q <= first_d;
      ptr_q <= ptr_d;
      sda_oe <= oe_d;
      req <= req_d;
    end
  end
endmodule // i2c_reg_slave
`default_nettype wire

// ==== verilog/chan_power_flags.sv ====
// per-channel power status flags, off-entry detection and change pulses
`timescale 1ns/1ps
`default_nettype none
`include "pse_regs_cfg.svh"
module chan_power_flags import pse_regs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // channel inputs
  input wire mode_t mode,
  input wire logic chan_on,
  input wire logic drain_low,
  // flags and pulses
  output logic supply_good_q,
  output logic chan_on_q,
  output logic off_entry_q,
  output logic sg_change_q,
  output logic on_change_q
);
  logic sg_d, on_d, off_d, sgc_d, onc_d;
  mode_t mode_q;

  // flag update and off-mode entry
  always_comb begin
    off_d = (mode == MODE_OFF) && (mode_q != MODE_OFF);
    on_d = chan_on && (mode != MODE_OFF);
    sg_d = on_d && (supply_good_q || drain_low);
    sgc_d = sg_d != supply_good_q;
    onc_d = on_d != chan_on_q;
  end

  // flag registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_good_q <= 1'b0;
      chan_on_q <= 1'b0;
      off_entry_q <= 1'b0;
      sg_change_q <= 1'b0;
      on_change_q <= 1'b0;
      mode_q <= MODE_OFF;
    end else begin
      supply_good_q <= sg_d;
      chan_on_q <= on_d;
      off_entry_q <= off_d;
      sg_change_q <= sgc_d;
      on_change_q <= onc_d;
      mode_q <= mode;
    end
  end
endmodule // chan_power_flags
`default_nettype wire

// ==== verification/pse_regs_props.sv ====
// assertion checker of the mode/status bank, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module pse_regs_props #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // i2c pins
  input wire logic scl_in,
  input wire logic sda_oe,
  // channel side
  input wire logic [NCH-1:0] chan_on,
  input wire logic [NCH-1:0] drain_low,
  input wire logic [2*NCH-1:0] channel_mode_field,
  input wire logic [NCH-1:0] power_allow,
  input wire logic [NCH-1:0] probe_allow,
  input wire logic [NCH-1:0] off_clear,
  input wire logic [NCH-1:0] supply_good_change_flag,
  input wire logic [NCH-1:0] channel_on_change_flag
);
  logic [NCH-1:0] live;
  // channels whose mode field is not off
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      live[i] = |channel_mode_field[2*i+:2];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // acknowledge and data change only while the bus clock is low
  property p_ack_edge;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("sda pulled during scl high");
  property p_ack_hold;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda moved in scl high");
  // an off channel gets neither power nor probing
  property p_off_quiet;
    ((power_allow | probe_allow) & ~live) == '0;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("off channel allowed");
  // clear pulse is one cycle and only for channels in off
  property p_clear_single;
    |off_clear |-> (off_clear & live) == '0 ##1 (off_clear & $past(off_clear)) == '0;
  endproperty
  a_clear_single: assert property (p_clear_single) else $error("bad clear pulse");
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    sequence s_leave;
      $past(live[i]) && !live[i];
    endsequence
    sequence s_lit;
      live[i] && $past(live[i]) && chan_on[i] && $past(chan_on[i]);
    endsequence
    property p_clear_entry;
      s_leave |-> ##[0:2] off_clear[i];
    endproperty
    a_clear_entry: assert property (p_clear_entry) else $error("no clear on off");
    property p_on_drop;
      s_lit ##1 s_leave |-> ##[0:3] channel_on_change_flag[i];
    endproperty
    a_on_drop: assert property (p_on_drop) else $error("no on change at off");
    property p_on_rise;
      live[i] && $past(live[i]) && $rose(chan_on[i]) |-> ##[1:3] channel_on_change_flag[i];
    endproperty
    a_on_rise: assert property (p_on_rise) else $error("no on change at turn on");
    property p_sg_rise;
      live[i] && $rose(chan_on[i]) && drain_low[i] |-> ##[1:3] supply_good_change_flag[i];
    endproperty
    a_sg_rise: assert property (p_sg_rise) else $error("no supply good change");
  end
endmodule // pse_regs_props
bind pse_channel_mode_status_regs pse_regs_props #(.NCH(NCH)) pse_regs_props_inst (
  .clk, .rst_b, .scl_in, .sda_oe, .chan_on, .drain_low, .channel_mode_field, .power_allow,
  .probe_allow, .off_clear, .supply_good_change_flag, .channel_on_change_flag);
`default_nettype wire

// ==== verification/i2c_host.sv ====
// i2c host model: drives bus clock and data, reads the line back
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
  // clock
  input wire logic clk,
  // bus
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one bus phase of three clocks, changed on the falling edge
  task automatic ph(input logic c, input logic d);
    @(negedge clk);
    scl = c;
    sda_rel = d;
    repeat (2) @(negedge clk);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start;
    ph(1'b0, sda_rel);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // stop: data rises while clock is high
  task automatic stop;
    ph(1'b0, sda_rel);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // eight bits msb first then acknowledge; data set while clock low
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    logic [8:0] v;
    logic [8:0] r;
    v = {d, a};
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, sda_rel);
      ph(1'b0, v[i]);
      ph(1'b1, v[i]);
      r[i] = sda;
    end
    q = r[8:1];
    k = r[0];
  endtask
endmodule // i2c_host
`default_nettype wire

// ==== verification/pse_channel_mode_status_regs_bench.sv ====
// self-checking bench of the mode/status register bank
`timescale 1ns/1ps
`default_nettype none
`include "pse_regs_cfg.svh"
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module pse_channel_mode_status_regs_bench import pse_regs_pkg::*; ();
  logic clk, rst_b, scl, sda_rel, sda_out, sda_oe, gsel, config_b, alloc, k, nak;
  logic [3:0] straps, chan_on, drain_low, power_allow, probe_allow;
  logic [7:0] mode_field, q;
  logic [6:0] dev;
  disc_in_t [3:0] disc;
  int n_mismatch = 0;
  int checked = 0;
  wire sda;
  // open-drain data line with pull-up
  assign sda = sda_rel & ~(sda_oe & ~sda_out);
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // block under test and the host on its bus
  pse_channel_mode_status_regs #(.NCH(4)) pse_channel_mode_status_regs_inst (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_pins(straps), .group_select_bit(gsel),
    .config_b(config_b), .chan_on(chan_on), .drain_low(drain_low), .disc_in(disc),
    .alloc_15w5(alloc), .channel_mode_field(mode_field), .power_allow(power_allow),
    .probe_allow(probe_allow), .off_clear(), .supply_good_change_flag(),
    .channel_on_change_flag());
  i2c_host host (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda));
  // reset for four cycles, bus traffic from the third falling edge after release
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // register write: address, pointer, data
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    logic [7:0] x;
    host.start();
    host.byte_x({a, 1'b0}, 1'b1, x, nak);
    if (nak === 1'b0) begin
      host.byte_x(r, 1'b1, x, k);
      host.byte_x(d, 1'b1, x, k);
    end
    host.stop();
  endtask
  // register read: pointer, repeated start, one byte closed by nack
  task automatic rd(input logic [7:0] r);
    logic [7:0] x;
    host.start();
    host.byte_x({dev, 1'b0}, 1'b1, x, k);
    host.byte_x(r, 1'b1, x, k);
    host.start();
    host.byte_x({dev, 1'b1}, 1'b1, x, k);
    host.byte_x(8'hff, 1'b1, q, k);
    host.stop();
  endtask
  // read and compare a whole register
  task automatic rchk(input logic [7:0] r, input logic [7:0] e);
    rd(r);
    `CHK("reg", e, q)
  endtask
  // reset values, strap view, refused writes and addresses
  task automatic t_reset;
    rchk(`REG_POWER, 8'h00);
    rchk(`REG_MODE, `MODE_RESET);
    rchk(`REG_STRAP, {1'b0, straps, gsel, 2'b00});
    rchk(8'h20, `UNMAPPED_DATA);
    wr(dev, `REG_POWER, 8'hff);
    rchk(`REG_POWER, 8'h00);
    wr(7'h36, `REG_MODE, 8'hff);
    `CHK("nack", 1'b1, nak)
    rchk(`REG_MODE, 8'h00);
  endtask
  // every mode code in every field, channel 1 lowest
  task automatic t_modes;
    logic [7:0] m [5];
    m = '{8'h00, 8'h55, 8'haa, 8'he4, 8'hff};
    foreach (m[i]) begin
      wr(dev, `REG_MODE, m[i]);
      rchk(`REG_MODE, m[i]);
      `CHK("mode", m[i], mode_field)
    end
  endtask
  // flags follow the channels, supply good latches, fault turn-off clears
  task automatic t_power;
    chan_on = 4'h3;
    drain_low = 4'h1;
    repeat (4) @(negedge clk);
    drain_low = 4'h0;
    rchk(`REG_POWER, 8'h13);
    chan_on = 4'h1;
    rchk(`REG_POWER, 8'h11);
    chan_on = 4'h0;
    rchk(`REG_POWER, 8'h00);
  endtask
  // channel 1 to off while channel 2 keeps running
  task automatic t_off;
    chan_on = 4'h3;
    drain_low = 4'h3;
    rchk(`REG_POWER, 8'h33);
    wr(dev, `REG_MODE, 8'hfc);
    repeat (4) @(negedge clk);
    `CHK("allow", 4'he, power_allow)
    `CHK("probe", 4'he, probe_allow)
    rchk(`REG_POWER, 8'h22);
    chan_on = 4'h0;
    drain_low = 4'h0;
  endtask
  // requested versus assigned class, manual channel 1 gets none, cleared on off entry
  task automatic t_class;
    wr(dev, `REG_MODE, 8'hfd);
    alloc = 1'b1;
    disc[0] = '{1'b1, `CLASS_4, 4'h4};
    disc[2] = '{1'b1, `CLASS_0, 4'h4};
    disc[3] = '{1'b1, `CLASS_4, 4'h4};
    @(negedge clk);
    disc = '0;
    chan_on = 4'hd;
    rchk(`REG_DISC_BASE + 8'h2, {`CLASS_0, 4'h4});
    rchk(`REG_DISC_LAST, {`CLASS_4P_LIM, 4'h4});
    rd(`REG_ASGN_BASE + 8'h2);
    `CHK("assigned", `CLASS_3, q[7:4])
    rd(`REG_ASGN_LAST);
    `CHK("assigned", `CLASS_4, q[7:4])
    rchk(`REG_ASGN_BASE, 8'h00);
    wr(dev, `REG_MODE, 8'h0f);
    rchk(`REG_DISC_LAST, 8'h00);
    rchk(`REG_ASGN_LAST, 8'h00);
    rchk(`REG_DISC_BASE, {`CLASS_4P_LIM, 4'h4});
    chan_on = 4'h0;
    alloc = 1'b0;
  endtask
  // configuration b forces group select low; broadcast reaches the bank
  task automatic t_cfgb;
    config_b = 1'b1;
    do_reset();
    dev = {`ADDR_PREFIX, straps, 1'b0};
    rchk(`REG_STRAP, {1'b0, straps, 3'h0});
    rchk(`REG_MODE, `MODE_RESET);
    wr({`ADDR_PREFIX, straps, 1'b1}, `REG_MODE, 8'h55);
    `CHK("nack", 1'b1, nak)
    wr(`ADDR_BCAST, `REG_MODE, 8'h99);
    rchk(`REG_MODE, 8'h99);
  endtask
  // print counts and verdict, end the run
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_b = 1'b0;
    straps = 4'ha;
    gsel = 1'b1;
    config_b = 1'b0;
    chan_on = 4'h0;
    drain_low = 4'h0;
    disc = '0;
    alloc = 1'b0;
    dev = {`ADDR_PREFIX, 4'ha, 1'b1};
    do_reset();
    t_reset();
    t_modes();
    t_power();
    t_off();
    t_class();
    t_cfgb();
    final_report();
  end
  // watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule // pse_channel_mode_status_regs_bench
`default_nettype wire
